// ==== core/avalon_reg_slave.sv ====
// avalon-mm slave front end for the single function select register
`timescale 1ns/1ns

module avalon_reg_slave (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // avalon-mm
    input wire logic [pin_mux_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [pin_mux_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [pin_mux_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // register side
    input wire logic [pin_mux_pkg::DATA_W-1:0] reg_value,
    output logic reg_wr,
    output logic [pin_mux_pkg::DATA_W-1:0] reg_wr_data,
    output logic [pin_mux_pkg::DATA_W-1:0] reg_wr_mask
);

    typedef struct packed {
        logic ack;
        logic [pin_mux_pkg::DATA_W-1:0] rdata;
    } slave_state_s;

    slave_state_s state_reg;
    slave_state_s state_next;
    logic hit;
    logic req;

    assign req = avs_read | avs_write;
    assign hit = (avs_address == pin_mux_pkg::SEL_ADDR);

    // one wait cycle: data is captured first, handed over on the accept edge
    always_comb begin
        state_next = state_reg;
        state_next.ack = req & ~state_reg.ack;
        if (avs_read && !state_reg.ack) begin
            state_next.rdata = hit ? reg_value : '0;
        end
        if (!rst_n) begin
            state_next = '0;
        end
    end

    always_ff @(posedge mclk) begin
        state_reg <= state_next;
    end

    assign avs_waitrequest = req & ~state_reg.ack;
    assign avs_readdata = state_reg.rdata;
    // unmapped writes are dropped
    assign reg_wr = avs_write & state_reg.ack & hit;
    assign reg_wr_data = avs_writedata;
    assign reg_wr_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

endmodule

// ==== core/level_sync.sv ====
// two-flop synchroniser for a group of pad levels
`timescale 1ns/1ns

module level_sync #(
    parameter int unsigned WIDTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_s;

    sync_state_s state_reg;
    sync_state_s state_next;

    always_comb begin
        state_next.stage1 = async_in;
        state_next.stage2 = state_reg.stage1;
        if (!rst_n) begin
            state_next = '0;
        end
    end

    always_ff @(posedge mclk) begin
        state_reg <= state_next;
    end

    assign sync_out = state_reg.stage2;

endmodule

// ==== core/pin_mux_pkg.sv ====
// shared constants, function codes and bundles for the port 0 upper pin mux
package pin_mux_pkg;

    localparam int unsigned PIN_COUNT = 16;
    localparam int unsigned PIN_BASE = 16;
    localparam int unsigned FIELD_W = 2;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 32;

    localparam logic [ADDR_W-1:0] SEL_ADDR = 32'he002c004;
    // pins 27..30 start on their analog inputs, the rest on port or nothing
    localparam logic [DATA_W-1:0] SEL_RESET = 32'h15400000;

    localparam logic [1:0] CODE_PORT = 2'h0;
    localparam logic [1:0] CODE_1 = 2'h1;
    localparam logic [1:0] CODE_2 = 2'h2;
    localparam logic [1:0] CODE_3 = 2'h3;

    typedef enum logic [4:0] {
        fn_gpio,
        fn_reserved,
        fn_external_interrupt_0,
        fn_external_interrupt_3,
        fn_t0_mat0,
        fn_t0_mat1,
        fn_t0_mat2,
        fn_t0_mat3,
        fn_t0_cap0,
        fn_t0_cap1,
        fn_t0_cap2,
        fn_t0_cap3,
        fn_t1_mat2,
        fn_t1_mat3,
        fn_t1_cap2,
        fn_t1_cap3,
        fn_spi_sck,
        fn_spi_miso,
        fn_spi_mosi,
        fn_spi_ssel,
        fn_pwm_output_5,
        fn_analog_input_0,
        fn_analog_input_1,
        fn_analog_input_2,
        fn_analog_input_3
    } pin_func_e;

    // outputs of the peripherals towards the pads
    typedef struct packed {
        logic [3:0] t0_match;
        logic [1:0] t1_match;
        logic spi_sck;
        logic spi_sck_oe;
        logic spi_miso;
        logic spi_miso_oe;
        logic spi_mosi;
        logic spi_mosi_oe;
        logic spi_ssel;
        logic spi_ssel_oe;
        logic pwm_output_5;
    } periph_out_s;

    // pad levels delivered to the peripherals, zero when not routed
    typedef struct packed {
        logic ext_int0;
        logic ext_int3;
        logic [3:0] t0_capture;
        logic [1:0] t1_capture;
        logic spi_sck;
        logic spi_miso;
        logic spi_mosi;
        logic spi_ssel;
    } periph_in_s;

endpackage

// ==== core/port0_upper_pin_function_mux.sv ====
// function multiplexer for port 0 pins 16 to 31
//
// What this block does
// RULE1 - the software direction bit steers a pad only while that pad is on its port function.
// RULE2 - on any peripheral function the pad direction follows the peripheral alone.
// RULE3 - software must not write reserved encodings; such pads are simply parked as inputs.
// RULE4 - sixteen two-bit fields, bits 2n+1:2n for pin 16+n, with 00 meaning port where defined.
// RULE5 - pins 23 to 25 only have the port function and pins 26 and 31 have none at all.
// RULE6 - pin 16 gives external_interrupt_0, t0 match2, t0 capture2; pin 28 gives analog_input_1, t0 capture2, match2.
// RULE7 - pin 17 gives t1 capture2, spi sck, t1 match2; pin 19 gives t1 match2, mosi, capture2.
// RULE8 - pin 18 gives t1 cap3/miso/match3, pin 20 t1 match3/ssel/external_interrupt_3, pin 21 pwm_output_5/t1 cap3.
// RULE9 - pin 22 gives t0 capture0 and match0 with 01 reserved; pin 30 analog_input_3, external_interrupt_3, t0 cap0.
// RULE10 - pin 27 gives analog input 0, t0 capture1 and t0 match1.
// RULE11 - pin 29 gives analog input 2, t0 capture3 and t0 match3.
// RULE12 - after reset pins 27 to 30 select their analog inputs and all other fields read 0.
// RULE13 - each pad carries its selected peripheral out and enable, and only it sees the pad.
`timescale 1ns/1ns

module port0_upper_pin_function_mux (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // avalon-mm register bus
    input wire logic [pin_mux_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [pin_mux_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [pin_mux_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // pads
    input wire logic [pin_mux_pkg::PIN_COUNT-1:0] pad_in,
    output logic [pin_mux_pkg::PIN_COUNT-1:0] pad_out,
    output logic [pin_mux_pkg::PIN_COUNT-1:0] pad_oe_n,
    output logic [pin_mux_pkg::PIN_COUNT-1:0] pad_analog,
    // general-purpose port
    input wire logic [pin_mux_pkg::PIN_COUNT-1:0] gpio_out,
    input wire logic [pin_mux_pkg::PIN_COUNT-1:0] pin_direction_register,
    output logic [pin_mux_pkg::PIN_COUNT-1:0] gpio_in,
    // peripherals
    input wire pin_mux_pkg::periph_out_s periph_out,
    output pin_mux_pkg::periph_in_s periph_in,
    output logic [3:0] analog_input_select
);

    typedef struct packed {
        logic [pin_mux_pkg::DATA_W-1:0] sel;
        logic [pin_mux_pkg::PIN_COUNT-1:0] pad_out;
        logic [pin_mux_pkg::PIN_COUNT-1:0] pad_oe_n;
        logic [pin_mux_pkg::PIN_COUNT-1:0] pad_analog;
        logic [pin_mux_pkg::PIN_COUNT-1:0] gpio_in;
        pin_mux_pkg::periph_in_s pin;
        logic [3:0] ain;
    } mux_state_s;

    mux_state_s state_reg;
    mux_state_s state_next;
    logic [pin_mux_pkg::PIN_COUNT-1:0] pad_sync;
    logic reg_wr;
    logic [pin_mux_pkg::DATA_W-1:0] reg_wr_data;
    logic [pin_mux_pkg::DATA_W-1:0] reg_wr_mask;

    avalon_reg_slave u_slave (
        .mclk(mclk),
        .rst_n(rst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .reg_value(state_reg.sel),
        .reg_wr(reg_wr),
        .reg_wr_data(reg_wr_data),
        .reg_wr_mask(reg_wr_mask)
    );

    // pads come from outside the clock domain
    level_sync #(
        .WIDTH(pin_mux_pkg::PIN_COUNT)
    ) u_pad_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(pad_in),
        .sync_out(pad_sync)
    );

    // function decode per pin index (0 = pin 16)
    function automatic pin_mux_pkg::pin_func_e func_of(input logic [3:0] idx,
                                                       input logic [1:0] code);
        pin_mux_pkg::pin_func_e f;
        f = pin_mux_pkg::fn_reserved;
        unique case (idx)
            4'h0: begin
                unique case (code) // RULE6
                    pin_mux_pkg::CODE_PORT: f = pin_mux_pkg::fn_gpio;
                    pin_mux_pkg::CODE_1: f = pin_mux_pkg::fn_external_interrupt_0;
                    pin_mux_pkg::CODE_2: f = pin_mux_pkg::fn_t0_mat2;
                    pin_mux_pkg::CODE_3: f = pin_mux_pkg::fn_t0_cap2;
                endcase
            end
            4'h1: begin
                unique case (code) // RULE7
                    pin_mux_pkg::CODE_PORT: f = pin_mux_pkg::fn_gpio;
                    pin_mux_pkg::CODE_1: f = pin_mux_pkg::fn_t1_cap2;
                    pin_mux_pkg::CODE_2: f = pin_mux_pkg::fn_spi_sck;
                    pin_mux_pkg::CODE_3: f = pin_mux_pkg::fn_t1_mat2;
                endcase
            end
            4'h2: begin
                unique case (code) // RULE8
                    pin_mux_pkg::CODE_PORT: f = pin_mux_pkg::fn_gpio;
                    pin_mux_pkg::CODE_1: f = pin_mux_pkg::fn_t1_cap3;
                    pin_mux_pkg::CODE_2: f = pin_mux_pkg::fn_spi_miso;
                    pin_mux_pkg::CODE_3: f = pin_mux_pkg::fn_t1_mat3;
                endcase
            end
            4'h3: begin
                unique case (code) // RULE7
                    pin_mux_pkg::CODE_PORT: f = pin_mux_pkg::fn_gpio;
                    pin_mux_pkg::CODE_1: f = pin_mux_pkg::fn_t1_mat2;
                    pin_mux_pkg::CODE_2: f = pin_mux_pkg::fn_spi_mosi;
                    pin_mux_pkg::CODE_3: f = pin_mux_pkg::fn_t1_cap2;
                endcase
            end
            4'h4: begin
                unique case (code) // RULE8
                    pin_mux_pkg::CODE_PORT: f = pin_mux_pkg::fn_gpio;
                    pin_mux_pkg::CODE_1: f = pin_mux_pkg::fn_t1_mat3;
                    pin_mux_pkg::CODE_2: f = pin_mux_pkg::fn_spi_ssel;
                    pin_mux_pkg::CODE_3: f = pin_mux_pkg::fn_external_interrupt_3;
                endcase
            end
            4'h5: begin
                unique case (code) // RULE8
                    pin_mux_pkg::CODE_PORT: f = pin_mux_pkg::fn_gpio;
                    pin_mux_pkg::CODE_1: f = pin_mux_pkg::fn_pwm_output_5;
                    pin_mux_pkg::CODE_2: f = pin_mux_pkg::fn_reserved;
                    pin_mux_pkg::CODE_3: f = pin_mux_pkg::fn_t1_cap3;
                endcase
            end
            4'h6: begin
                unique case (code) // RULE9
                    pin_mux_pkg::CODE_PORT: f = pin_mux_pkg::fn_gpio;
                    pin_mux_pkg::CODE_1: f = pin_mux_pkg::fn_reserved;
                    pin_mux_pkg::CODE_2: f = pin_mux_pkg::fn_t0_cap0;
                    pin_mux_pkg::CODE_3: f = pin_mux_pkg::fn_t0_mat0;
                endcase
            end
            4'h7, 4'h8, 4'h9: begin
                // port function only
                if (code == pin_mux_pkg::CODE_PORT) begin // RULE5
                    f = pin_mux_pkg::fn_gpio;
                end
            end
            4'hb: begin
                unique case (code) // RULE10
                    pin_mux_pkg::CODE_PORT: f = pin_mux_pkg::fn_gpio;
                    pin_mux_pkg::CODE_1: f = pin_mux_pkg::fn_analog_input_0;
                    pin_mux_pkg::CODE_2: f = pin_mux_pkg::fn_t0_cap1;
                    pin_mux_pkg::CODE_3: f = pin_mux_pkg::fn_t0_mat1;
                endcase
            end
            4'hc: begin
                unique case (code) // RULE6
                    pin_mux_pkg::CODE_PORT: f = pin_mux_pkg::fn_gpio;
                    pin_mux_pkg::CODE_1: f = pin_mux_pkg::fn_analog_input_1;
                    pin_mux_pkg::CODE_2: f = pin_mux_pkg::fn_t0_cap2;
                    pin_mux_pkg::CODE_3: f = pin_mux_pkg::fn_t0_mat2;
                endcase
            end
            4'hd: begin
                unique case (code) // RULE11
                    pin_mux_pkg::CODE_PORT: f = pin_mux_pkg::fn_gpio;
                    pin_mux_pkg::CODE_1: f = pin_mux_pkg::fn_analog_input_2;
                    pin_mux_pkg::CODE_2: f = pin_mux_pkg::fn_t0_cap3;
                    pin_mux_pkg::CODE_3: f = pin_mux_pkg::fn_t0_mat3;
                endcase
            end
            4'he: begin
                unique case (code) // RULE9
                    pin_mux_pkg::CODE_PORT: f = pin_mux_pkg::fn_gpio;
                    pin_mux_pkg::CODE_1: f = pin_mux_pkg::fn_analog_input_3;
                    pin_mux_pkg::CODE_2: f = pin_mux_pkg::fn_external_interrupt_3;
                    pin_mux_pkg::CODE_3: f = pin_mux_pkg::fn_t0_cap0;
                endcase
            end
            // pins 26 and 31 have nothing behind them
            4'ha, 4'hf: f = pin_mux_pkg::fn_reserved; // RULE5
        endcase
        return f;
    endfunction

    always_comb begin
        pin_mux_pkg::pin_func_e f;
        logic p;
        f = pin_mux_pkg::fn_reserved;
        p = 1'b0;
        state_next = state_reg;
        if (reg_wr) begin
            state_next.sel = (state_reg.sel & ~reg_wr_mask) | (reg_wr_data & reg_wr_mask);
        end
        state_next.pin = '0;
        state_next.ain = '0;
        for (int i = 0; i < pin_mux_pkg::PIN_COUNT; i++) begin
            f = func_of(4'(i), state_reg.sel[pin_mux_pkg::FIELD_W*i +: 2]); // RULE4
            p = pad_sync[i];
            // reserved codes park the pad as an undriven input
            state_next.pad_out[i] = 1'b0; // RULE3
            state_next.pad_oe_n[i] = 1'b1;
            state_next.pad_analog[i] = 1'b0;
            state_next.gpio_in[i] = 1'b0;
            unique case (f)
                pin_mux_pkg::fn_gpio: begin
                    state_next.pad_out[i] = gpio_out[i];
                    state_next.pad_oe_n[i] = ~pin_direction_register[i]; // RULE1
                    state_next.gpio_in[i] = p; // RULE13
                end
                pin_mux_pkg::fn_reserved: begin
                end
                pin_mux_pkg::fn_external_interrupt_0: state_next.pin.ext_int0 |= p; // RULE13
                pin_mux_pkg::fn_external_interrupt_3: state_next.pin.ext_int3 |= p; // RULE13
                pin_mux_pkg::fn_t0_mat0,
                pin_mux_pkg::fn_t0_mat1,
                pin_mux_pkg::fn_t0_mat2,
                pin_mux_pkg::fn_t0_mat3: begin
                    state_next.pad_out[i] = periph_out.t0_match[2'(f - pin_mux_pkg::fn_t0_mat0)];
                    state_next.pad_oe_n[i] = 1'b0; // RULE2
                end
                pin_mux_pkg::fn_t0_cap0,
                pin_mux_pkg::fn_t0_cap1,
                pin_mux_pkg::fn_t0_cap2,
                pin_mux_pkg::fn_t0_cap3: begin
                    state_next.pin.t0_capture[2'(f - pin_mux_pkg::fn_t0_cap0)] |= p; // RULE13
                end
                pin_mux_pkg::fn_t1_mat2,
                pin_mux_pkg::fn_t1_mat3: begin
                    state_next.pad_out[i] = periph_out.t1_match[1'(f - pin_mux_pkg::fn_t1_mat2)];
                    state_next.pad_oe_n[i] = 1'b0; // RULE2
                end
                pin_mux_pkg::fn_t1_cap2,
                pin_mux_pkg::fn_t1_cap3: begin
                    state_next.pin.t1_capture[1'(f - pin_mux_pkg::fn_t1_cap2)] |= p;
                end
                pin_mux_pkg::fn_spi_sck: begin
                    state_next.pad_out[i] = periph_out.spi_sck;
                    state_next.pad_oe_n[i] = ~periph_out.spi_sck_oe; // RULE2
                    state_next.pin.spi_sck = p;
                end
                pin_mux_pkg::fn_spi_miso: begin
                    state_next.pad_out[i] = periph_out.spi_miso;
                    state_next.pad_oe_n[i] = ~periph_out.spi_miso_oe; // RULE2
                    state_next.pin.spi_miso = p;
                end
                pin_mux_pkg::fn_spi_mosi: begin
                    state_next.pad_out[i] = periph_out.spi_mosi;
                    state_next.pad_oe_n[i] = ~periph_out.spi_mosi_oe; // RULE2
                    state_next.pin.spi_mosi = p;
                end
                pin_mux_pkg::fn_spi_ssel: begin
                    state_next.pad_out[i] = periph_out.spi_ssel;
                    state_next.pad_oe_n[i] = ~periph_out.spi_ssel_oe; // RULE2
                    state_next.pin.spi_ssel = p;
                end
                pin_mux_pkg::fn_pwm_output_5: begin
                    state_next.pad_out[i] = periph_out.pwm_output_5;
                    state_next.pad_oe_n[i] = 1'b0; // RULE2
                end
                pin_mux_pkg::fn_analog_input_0,
                pin_mux_pkg::fn_analog_input_1,
                pin_mux_pkg::fn_analog_input_2,
                pin_mux_pkg::fn_analog_input_3: begin
                    // digital driver off, pad handed to the converter
                    state_next.pad_analog[i] = 1'b1; // RULE2
                    state_next.ain[2'(f - pin_mux_pkg::fn_analog_input_0)] = 1'b1;
                end
            endcase
        end
        if (!rst_n) begin
            state_next = '0;
            state_next.sel = pin_mux_pkg::SEL_RESET; // RULE12
            state_next.pad_oe_n = '1;
        end
    end

    always_ff @(posedge mclk) begin
        state_reg <= state_next;
    end

    assign pad_out = state_reg.pad_out;
    assign pad_oe_n = state_reg.pad_oe_n;
    assign pad_analog = state_reg.pad_analog;
    assign gpio_in = state_reg.gpio_in;
    assign periph_in = state_reg.pin;
    assign analog_input_select = state_reg.ain;

endmodule

// ==== verif/pin_mux_checker.sv ====
// concurrent checks on the pin mux top ports
`timescale 1ns/1ns

module pin_mux_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register bus
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // pads and port
    input wire logic [15:0] pad_in,
    input wire logic [15:0] pad_out,
    input wire logic [15:0] pad_oe_n,
    input wire logic [15:0] pad_analog,
    input wire logic [15:0] gpio_out,
    input wire logic [15:0] pin_direction_register,
    input wire logic [15:0] gpio_in,
    // peripherals
    input wire pin_mux_pkg::periph_out_s periph_out,
    input wire pin_mux_pkg::periph_in_s periph_in,
    input wire logic [3:0] analog_input_select
);
    logic [31:0] sel_reg;
    logic [31:0] sel_next;
    logic [31:0] be_mask;
    logic [15:0] port_mask;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // shadow of the select register, updated at the accepting edge only
    always_comb begin
        sel_next = sel_reg;
        if (avs_write && !avs_waitrequest && avs_address == pin_mux_pkg::SEL_ADDR) begin
            sel_next = (sel_reg & ~be_mask) | (avs_writedata & be_mask);
        end
        for (int i = 0; i < 16; i++) begin
            port_mask[i] = (sel_reg[2*i+:2] == 2'h0);
        end
        // pins 26 and 31 have no port function
        port_mask[10] = 1'b0;
        port_mask[15] = 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sel_reg <= pin_mux_pkg::SEL_RESET;
        end else begin
            sel_reg <= sel_next;
        end
    end

    property p_bus_wait;
        $rose(avs_read) || $rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("wait cycle count wrong");
    property p_readback;
        avs_read && !avs_waitrequest && avs_address == pin_mux_pkg::SEL_ADDR |-> avs_readdata == sel_reg;
    endproperty
    a_readback: assert property (p_readback) else $error("select readback wrong");
    property p_port_dir;
        1 |=> ((pad_oe_n ^ ~$past(pin_direction_register)) & $past(port_mask)) == 16'h0;
    endproperty
    a_port_dir: assert property (p_port_dir) else $error("port direction wrong");
    property p_pwm_output_5;
        sel_reg[11:10] == 2'h1 |=> !pad_oe_n[5] && pad_out[5] == $past(periph_out.pwm_output_5);
    endproperty
    a_pwm_output_5: assert property (p_pwm_output_5) else $error("pin 21 pwm route wrong");
    property p_match_p16;
        sel_reg[1:0] == 2'h2 |=> !pad_oe_n[0] && pad_out[0] == $past(periph_out.t0_match[2]);
    endproperty
    a_match_p16: assert property (p_match_p16) else $error("pin 16 match route wrong");
    property p_sck_dir;
        sel_reg[3:2] == 2'h2 |=> pad_oe_n[1] == !$past(periph_out.spi_sck_oe);
    endproperty
    a_sck_dir: assert property (p_sck_dir) else $error("pin 17 clock direction wrong");
    property p_external_interrupt_0;
        (sel_reg[1:0] == 2'h1) [*2] |-> periph_in.ext_int0 == $past(pad_in[0], 3);
    endproperty
    a_external_interrupt_0: assert property (p_external_interrupt_0) else $error("pin 16 input route wrong");
    property p_match_p27;
        sel_reg[23:22] == 2'h3 |=> !pad_oe_n[11] && pad_out[11] == $past(periph_out.t0_match[1]);
    endproperty
    a_match_p27: assert property (p_match_p27) else $error("pin 27 match route wrong");
    property p_reserved;
        1 |-> pad_oe_n[10] && pad_oe_n[15];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved pin driven");
    property p_reset_analog;
        $rose(rst_n) |=> pad_analog == 16'h7800 && analog_input_select == 4'hf;
    endproperty
    a_reset_analog: assert property (p_reset_analog) else $error("reset analog wrong");
    property p_analog_p29;
        sel_reg[27:26] == 2'h1 |=> pad_analog[13] && pad_oe_n[13] && analog_input_select[2];
    endproperty
    a_analog_p29: assert property (p_analog_p29) else $error("pin 29 analog wrong");
endmodule

// ==== verif/port0_upper_pin_function_mux_test.sv ====
// self-checking bench for the port 0 upper pin function mux
`timescale 1ns/1ns

`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module port0_upper_pin_function_mux_test;
    // rows: all port, port with inputs, then 11, 10, 01 wherever that code is defined
    localparam logic [31:0] SEL_TAB [5] = '{32'h0, 32'h0, 32'h3fc03fff, 32'h2a8022aa,
        32'h15400555};
    localparam logic [15:0] OEN_TAB [5] = '{16'h8400, 16'hffff, 16'hc439, 16'hfc54, 16'hfc07};
    localparam logic [15:0] OUT_TAB [5] = '{16'h5a3c, 16'h0, 16'h1242, 16'h0223, 16'h0228};
    localparam logic [15:0] MSK_TAB [5] = '{16'h7bff, 16'h0, 16'h3bc6, 16'h03ab, 16'h03f8};
    localparam logic [11:0] IN_TAB [5] = '{12'h0, 12'h0, 12'h570, 12'h7cf, 12'h830};
    localparam logic [15:0] GIN_TAB [5] = '{16'h7bff, 16'h7bff, 16'h0380, 16'h03a0, 16'h03c0};
    logic mclk;
    logic rst_n;
    logic [31:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [15:0] pad_in;
    logic [15:0] pad_out;
    logic [15:0] pad_oe_n;
    logic [15:0] pad_analog;
    logic [15:0] gpio_out;
    logic [15:0] pin_direction_register;
    logic [15:0] gpio_in;
    pin_mux_pkg::periph_out_s periph_out;
    pin_mux_pkg::periph_in_s periph_in;
    logic [3:0] analog_input_select;
    logic [31:0] rd;
    int error_cnt = 0;
    int total_checks = 0;

    port0_upper_pin_function_mux i_port0_upper_pin_function_mux (.mclk(mclk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_analog(pad_analog), .gpio_out(gpio_out),
        .pin_direction_register(pin_direction_register), .gpio_in(gpio_in),
        .periph_out(periph_out), .periph_in(periph_in),
        .analog_input_select(analog_input_select));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // two low edges; the first one already loads every flop with its reset value
    task automatic reset_and_check();
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        bus(1'b0, pin_mux_pkg::SEL_ADDR, 32'h0, 4'hf, rd);
        `CHK("select reset", pin_mux_pkg::SEL_RESET, rd)
        `CHK("analog reset", 16'h7800, pad_analog)
        `CHK("analog select reset", 4'hf, analog_input_select)
        `CHK("oe after reset", 16'hfc00, pad_oe_n)
        $display("test reset done");
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        avs_address = 32'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        pad_in = 16'hffff;
        gpio_out = 16'h5a3c;
        pin_direction_register = 16'hffff;
        periph_out = '{t0_match: 4'h5, t1_match: 2'h1, spi_sck: 1'b1, spi_sck_oe: 1'b1,
            spi_miso: 1'b1, spi_miso_oe: 1'b0, spi_mosi: 1'b0, spi_mosi_oe: 1'b1,
            spi_ssel: 1'b1, spi_ssel_oe: 1'b0, pwm_output_5: 1'b1};
        reset_and_check();
        for (int r = 0; r < 5; r++) begin
            pin_direction_register <= (r == 1) ? 16'h0 : 16'hffff;
            bus(1'b1, pin_mux_pkg::SEL_ADDR, SEL_TAB[r], 4'hf, rd);
            // pads settle after one edge, inputs after three
            repeat (4) @(posedge mclk);
            `CHK("pad_oe_n", OEN_TAB[r], pad_oe_n)
            `CHK("pad_out", OUT_TAB[r], pad_out & MSK_TAB[r])
            `CHK("periph_in", IN_TAB[r], periph_in)
            `CHK("gpio_in", GIN_TAB[r], gpio_in)
            `CHK("analog_input_select", (r == 4) ? 4'hf : 4'h0, analog_input_select)
            `CHK("pad_analog", (r == 4) ? 16'h7800 : 16'h0, pad_analog)
            bus(1'b0, pin_mux_pkg::SEL_ADDR, 32'h0, 4'hf, rd);
            `CHK("select readback", SEL_TAB[r], rd)
            $display("test row %0d done", r);
        end
        periph_out.pwm_output_5 <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK("pwm follows", 1'b0, pad_out[5])
        bus(1'b1, pin_mux_pkg::SEL_ADDR, 32'hffff3fff, 4'h2, rd);
        bus(1'b1, 32'he002c000, 32'h0, 4'hf, rd);
        bus(1'b0, pin_mux_pkg::SEL_ADDR, 32'h0, 4'hf, rd);
        `CHK("byte lane write", 32'h15403f55, rd)
        bus(1'b0, 32'he002c008, 32'h0, 4'hf, rd);
        `CHK("unmapped read", 32'h0, rd)
        $display("test bus lanes done");
        reset_and_check();
        end_of_test();
    end
endmodule

bind port0_upper_pin_function_mux pin_mux_checker i_pin_mux_checker (.mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_analog(pad_analog), .gpio_out(gpio_out),
    .pin_direction_register(pin_direction_register), .gpio_in(gpio_in),
    .periph_out(periph_out), .periph_in(periph_in), .analog_input_select(analog_input_select));
